// [shared/dbd_pkg.sv]
// constants, states and helpers shared by the dual bank dram controller
package dbd_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int T_RCD_NS = 20;
  localparam int T_CAS_NS = 40;
  localparam int T_RP_NS = 30;
  localparam int T_RAS_NS = 60;
  localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CLKS = 40;
  localparam int PDI_SLOT = 5;
  localparam int CFG_BITS = 8;
  localparam int WAKE_CYCLES = 8;
  localparam int WAKE_CLKS = 32;
  localparam int WAKE_RAS_CLKS = 16;
  // ****************************************
  // refresh
  // ****************************************
  localparam int REF_WIN_NS = 2000000;
  localparam int REF_ROWS = 128;
  localparam int REF_ROWS_FAST = 256;
  localparam int REF_BASE = REF_WIN_NS / REF_ROWS / CLK_NS;
  localparam int REF_BASE_FAST = REF_WIN_NS / REF_ROWS_FAST / CLK_NS;
  localparam int REF_KEEP_PCT = 95;
  localparam int REF_STEP_PCT = 10;
  localparam logic [7:0] BURST_ROWS = 8'h80;
  localparam logic [2:0] RM_INT = 3'h0;
  localparam logic [2:0] RM_EXT_FS = 3'h1;
  localparam logic [2:0] RM_EXT = 3'h2;
  localparam logic [2:0] RM_BURST = 3'h3;
  localparam logic [2:0] RM_NONE = 3'h4;
  // ****************************************
  // programming word and pins
  // ****************************************
  localparam int CFG_ASYNC = 0;
  localparam int CFG_RB = 1;
  localparam int CFG_RFP = 2;
  localparam int CFG_MODE = 3;
  localparam int CFG_SHORT = 6;
  localparam logic [7:0] CFG_DEFAULT = 8'h02;
  localparam int P_RD = 0;
  localparam int P_WR = 1;
  localparam int P_PE = 2;
  localparam int P_PORT_CONTROL = 3;
  localparam int P_PDI = 4;
  localparam int P_REFRESH_REQUEST = 5;
  localparam int P_BS = 6;
  localparam int P_ADDR = 7;
  localparam int PADDR_W = 18;
  localparam int DRAM_AW = 9;
  localparam int PIN_W = P_ADDR + PADDR_W;
  localparam logic [8:0] ADDR_RST = 9'h1f8;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_SWREF = 0;
  localparam int CTRL_HOLD = 1;

  typedef enum logic [2:0] {
    ST_PROG = 3'h0,
    ST_WAKE = 3'h1,
    ST_IDLE = 3'h2,
    ST_ROW = 3'h3,
    ST_COL = 3'h4,
    ST_END = 3'h5,
    ST_REF = 3'h6
  } dbd_state_e;

  function automatic logic [11:0] ref_limit(input logic rfp, input logic [1:0] sh);
    int b;
    int p;
    b = rfp ? REF_BASE_FAST : REF_BASE;
    p = REF_KEEP_PCT - REF_STEP_PCT * int'(sh);
    return 12'(b * p / 100);
  endfunction
endpackage

// [hw/dbd_ctrl.sv]
// dual bank dram controller with avalon-mm control and status
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dbd_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmd_rd_n,
  input wire logic cmd_wr_n,
  input wire logic port_enable_n,
  input wire logic port_control,
  input wire logic bank_select_input,
  input wire logic refresh_request,
  input wire logic program_data_input,
  input wire logic [17:0] proc_addr,
  output logic [1:0] ras_n,
  output logic [1:0] cas_n,
  output logic we_n,
  output logic [8:0] dram_addr,
  output logic ready_n,
  output logic prog_shift_clk
);
  typedef struct packed {
    logic [dbd_pkg::PIN_W-1:0] s1;
    logic [dbd_pkg::PIN_W-1:0] s2;
    logic [3:0] s3;
    dbd_pkg::dbd_state_e st;
    logic in_rst;
    logic [2:0] straps;
    logic [7:0] cfg;
    logic [11:0] cnt;
    logic [2:0] wake;
    logic [11:0] ref_tmr;
    logic ref_pend;
    logic [7:0] ref_row;
    logic [7:0] burst;
    logic [3:0] pre0;
    logic [3:0] pre1;
    logic [1:0] mask;
    logic wr;
    logic last_rd;
    logic refresh_request_prev;
    logic hold;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] ras;
    logic [1:0] cas;
    logic we;
    logic rdy;
    logic pclk;
    logic [8:0] addr;
  } dbd_regs_s;

  dbd_regs_s q_q;
  dbd_regs_s q_d;
  logic [dbd_pkg::PIN_W-1:0] pins;
  logic [3:0] cmd;
  logic c_rd;
  logic c_wr;
  logic c_pe;
  logic ext_edge;
  logic rdy_phase;
  logic [2:0] mode;
  logic [1:0] smask;
  logic pre_ok;
  logic skip_pre;
  logic set_pend;
  logic clr_pend;
  logic sw_ref;
  logic [11:0] lim;
  logic [2:0] ph;

  assign pins = {proc_addr, bank_select_input, refresh_request, program_data_input,
                 port_control, port_enable_n, cmd_wr_n, cmd_rd_n};
  // ****************************************
  // command path and decode
  // ****************************************
  assign cmd = q_q.cfg[dbd_pkg::CFG_ASYNC] ? q_q.s3 : q_q.s2[3:0];
  assign c_rd = ~cmd[dbd_pkg::P_RD];
  assign c_wr = ~cmd[dbd_pkg::P_WR];
  assign c_pe = ~cmd[dbd_pkg::P_PE];
  assign rdy_phase = (q_q.st != dbd_pkg::ST_PROG) && (q_q.st != dbd_pkg::ST_WAKE);
  assign ext_edge = rdy_phase & q_q.s2[dbd_pkg::P_REFRESH_REQUEST] & ~q_q.refresh_request_prev;
  assign mode = q_q.cfg[dbd_pkg::CFG_MODE +: 3];
  assign lim = dbd_pkg::ref_limit(q_q.cfg[dbd_pkg::CFG_RFP],
                                  q_q.cfg[dbd_pkg::CFG_SHORT +: 2]);
  assign smask = !q_q.cfg[dbd_pkg::CFG_RB] ? 2'h3 :
                 (q_q.s2[dbd_pkg::P_BS] ? 2'h2 : 2'h1);
  assign skip_pre = !q_q.cfg[dbd_pkg::CFG_ASYNC] && c_rd && !c_wr &&
                    q_q.last_rd && (q_q.mask == smask);
  assign pre_ok = skip_pre ||
                  ((smask & {q_q.pre1 != 4'h0, q_q.pre0 != 4'h0}) == 2'h0);
  assign ph = 3'(q_q.cnt % dbd_pkg::PDI_SLOT);
  assign avs_waitrequest = (avs_read | avs_write) & ~q_q.ack;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    q_d = q_q;
    set_pend = 1'b0;
    clr_pend = 1'b0;
    sw_ref = 1'b0;
    q_d.s1 = pins;
    q_d.s2 = q_q.s1;
    q_d.s3 = q_q.s2[3:0];
    q_d.in_rst = 1'b0;
    q_d.refresh_request_prev = q_q.s2[dbd_pkg::P_REFRESH_REQUEST];
    q_d.ack = (avs_read | avs_write) & ~q_q.ack;
    if (q_q.in_rst) begin
      q_d.straps = {q_q.s2[dbd_pkg::P_PDI], q_q.s2[dbd_pkg::P_REFRESH_REQUEST],
                    q_q.s2[dbd_pkg::P_PORT_CONTROL]};
    end
    if (q_q.pre0 != 4'h0) begin
      q_d.pre0 = q_q.pre0 - 4'h1;
    end
    if (q_q.pre1 != 4'h0) begin
      q_d.pre1 = q_q.pre1 - 4'h1;
    end
    // register bus
    if (avs_read && !q_q.ack) begin
      if (avs_address == dbd_pkg::REG_STATUS) begin
        q_d.rdata = {9'h000, q_q.ref_pend, q_q.ref_row, q_q.straps, q_q.cfg, q_q.st};
      end else if (avs_address == dbd_pkg::REG_CTRL) begin
        q_d.rdata = {30'h00000000, q_q.hold, 1'b0};
      end else begin
        q_d.rdata = 32'h00000000;
      end
    end
    if (avs_write && q_q.ack && avs_address == dbd_pkg::REG_CTRL) begin
      sw_ref = avs_writedata[dbd_pkg::CTRL_SWREF];
      q_d.hold = avs_writedata[dbd_pkg::CTRL_HOLD];
    end
    // refresh request sources
    if (rdy_phase && (mode == dbd_pkg::RM_INT || mode == dbd_pkg::RM_EXT_FS)) begin
      if (q_q.ref_tmr >= lim) begin
        q_d.ref_tmr = 12'h000;
        set_pend = 1'b1;
      end else begin
        q_d.ref_tmr = q_q.ref_tmr + 12'h001;
      end
    end
    if (ext_edge && (mode == dbd_pkg::RM_EXT_FS || mode == dbd_pkg::RM_EXT)) begin
      set_pend = 1'b1;
      q_d.ref_tmr = 12'h000;
    end
    if (ext_edge && mode == dbd_pkg::RM_BURST) begin
      q_d.burst = dbd_pkg::BURST_ROWS;
    end
    if (sw_ref && rdy_phase && mode < dbd_pkg::RM_NONE) begin
      set_pend = 1'b1;
    end
    case (q_q.st)
      dbd_pkg::ST_PROG: begin
        q_d.cnt = q_q.cnt + 12'h001;
        q_d.pclk = (ph >= 3'h2);
        if (ph == 3'h4 && q_q.straps[2]) begin
          q_d.cfg = {q_q.s2[dbd_pkg::P_PDI], q_q.cfg[7:1]};
        end
        if (q_q.cnt == 12'(dbd_pkg::PROG_CLKS - 1)) begin
          q_d.st = dbd_pkg::ST_WAKE;
          q_d.cnt = 12'h000;
          q_d.pclk = 1'b1;
        end
      end
      dbd_pkg::ST_WAKE: begin
        q_d.cnt = q_q.cnt + 12'h001;
        q_d.ras = (q_q.cnt < 12'(dbd_pkg::WAKE_RAS_CLKS)) ? 2'h0 : 2'h3;
        if (q_q.cnt == 12'(dbd_pkg::WAKE_CLKS - 1)) begin
          q_d.cnt = 12'h000;
          q_d.wake = q_q.wake + 3'h1;
          q_d.ras = 2'h3;
          if (q_q.wake == 3'(dbd_pkg::WAKE_CYCLES - 1)) begin
            q_d.st = dbd_pkg::ST_IDLE;
          end
        end
      end
      dbd_pkg::ST_IDLE: begin
        if ((q_q.ref_pend || q_q.burst != 8'h00) &&
            q_q.pre0 == 4'h0 && q_q.pre1 == 4'h0) begin
          q_d.st = dbd_pkg::ST_REF;
          q_d.cnt = 12'h000;
          q_d.ras = 2'h0;
          q_d.addr = {1'b0, q_q.ref_row};
        end else if (!q_q.ref_pend && q_q.burst == 8'h00 && c_pe && (c_rd || c_wr) &&
                     pre_ok && !q_q.hold) begin
          q_d.st = dbd_pkg::ST_ROW;
          q_d.cnt = 12'h000;
          q_d.mask = smask;
          q_d.wr = c_wr;
          q_d.ras = ~smask;
          q_d.addr = q_q.s2[dbd_pkg::P_ADDR +: dbd_pkg::DRAM_AW];
        end
      end
      dbd_pkg::ST_ROW: begin
        q_d.cnt = q_q.cnt + 12'h001;
        if (q_q.cnt == 12'(dbd_pkg::RCD_CYC - 1)) begin
          q_d.st = dbd_pkg::ST_COL;
          q_d.cnt = 12'h000;
          q_d.cas = ~q_q.mask;
          q_d.we = ~q_q.wr;
          q_d.addr = q_q.s2[dbd_pkg::P_ADDR + dbd_pkg::DRAM_AW +: dbd_pkg::DRAM_AW];
        end
      end
      dbd_pkg::ST_COL: begin
        q_d.cnt = q_q.cnt + 12'h001;
        if (q_q.cnt == 12'(dbd_pkg::CAS_CYC - 1)) begin
          q_d.st = dbd_pkg::ST_END;
          q_d.rdy = 1'b0;
        end
      end
      dbd_pkg::ST_END: begin
        if (!c_rd && !c_wr) begin
          q_d.st = dbd_pkg::ST_IDLE;
          q_d.ras = 2'h3;
          q_d.cas = 2'h3;
          q_d.we = 1'b1;
          q_d.rdy = 1'b1;
          q_d.last_rd = ~q_q.wr;
          if (q_q.mask[0]) begin
            q_d.pre0 = 4'(dbd_pkg::RP_CYC);
          end
          if (q_q.mask[1]) begin
            q_d.pre1 = 4'(dbd_pkg::RP_CYC);
          end
        end
      end
      dbd_pkg::ST_REF: begin
        q_d.cnt = q_q.cnt + 12'h001;
        if (q_q.cnt == 12'(dbd_pkg::RAS_CYC - 1)) begin
          q_d.st = dbd_pkg::ST_IDLE;
          q_d.ras = 2'h3;
          q_d.pre0 = 4'(dbd_pkg::RP_CYC);
          q_d.pre1 = 4'(dbd_pkg::RP_CYC);
          q_d.ref_row = q_q.ref_row + 8'h01;
          q_d.last_rd = 1'b0;
          clr_pend = 1'b1;
          if (q_q.burst != 8'h00) begin
            q_d.burst = q_q.burst - 8'h01;
          end
        end
      end
      default: begin
        q_d.st = dbd_pkg::ST_IDLE;
      end
    endcase
    q_d.ref_pend = (q_q.ref_pend & ~clr_pend) | set_pend;
    if (sys_rst) begin
      q_d = '0;
      q_d.st = dbd_pkg::ST_PROG;
      q_d.in_rst = 1'b1;
      q_d.cfg = dbd_pkg::CFG_DEFAULT;
      q_d.ras = 2'h3;
      q_d.cas = 2'h3;
      q_d.we = 1'b1;
      q_d.rdy = 1'b1;
      q_d.pclk = 1'b1;
      q_d.addr = dbd_pkg::ADDR_RST;
      q_d.s1 = pins;
      q_d.s2 = q_q.s1;
      q_d.s3 = q_q.s2[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    q_q <= q_d;
  end

  assign avs_readdata = q_q.rdata;
  assign ras_n = q_q.ras;
  assign cas_n = q_q.cas;
  assign we_n = q_q.we;
  assign dram_addr = q_q.addr;
  assign ready_n = q_q.rdy;
  assign prog_shift_clk = q_q.pclk;

  // ****************************************
  // checks
  // ****************************************
  chk_reset_levels: assert property (@(posedge mclk) $past(sys_rst) |->
    (ras_n == 2'h3 && cas_n == 2'h3 && we_n && ready_n && dram_addr == 9'h1f8))
    else $error("outputs not at reset levels");
  chk_prog_length: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(q_q.st == dbd_pkg::ST_WAKE) |-> $past(q_q.cnt) == 12'd39)
    else $error("programming length wrong");
  chk_wake_count: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(q_q.st == dbd_pkg::ST_IDLE) && $past(q_q.st) == dbd_pkg::ST_WAKE
    |-> $past(q_q.wake) == 3'h7 && $past(q_q.cnt) == 12'd31)
    else $error("wake-up count wrong");
  chk_ext_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
    !rdy_phase |-> !set_pend) else $error("refresh accepted too early");
  chk_strobe_pair: assert property (@(posedge mclk) disable iff (sys_rst)
    (!q_q.cfg[dbd_pkg::CFG_RB] && q_q.st == dbd_pkg::ST_COL) |-> cas_n == 2'h0)
    else $error("single bank strobes split");
  chk_precharge: assert property (@(posedge mclk) disable iff (sys_rst)
    (q_q.st == dbd_pkg::ST_IDLE && q_d.st == dbd_pkg::ST_ROW && !skip_pre)
    |-> (smask & {q_q.pre1 != 4'h0, q_q.pre0 != 4'h0}) == 2'h0)
    else $error("bank opened during precharge");
  chk_refresh_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    (q_q.st == dbd_pkg::ST_IDLE && q_q.ref_pend && q_q.pre0 == 4'h0 && q_q.pre1 == 4'h0)
    |=> q_q.st == dbd_pkg::ST_REF && ras_n == 2'h0 && ready_n)
    else $error("refresh lost arbitration");
  chk_prog_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    q_q.st == dbd_pkg::ST_PROG |-> ras_n == 2'h3 && cas_n == 2'h3 && ready_n)
    else $error("command acted on while programming");
  chk_ref_interval: assert property (@(posedge mclk) disable iff (sys_rst)
    q_q.ref_tmr == lim && rdy_phase && mode == dbd_pkg::RM_INT |=> q_q.ref_pend)
    else $error("interval expiry missed");
  chk_bus_answer: assert property (@(posedge mclk) disable iff (sys_rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule
`default_nettype wire

// [test/dbd_proc_model.sv]
// processor port driver and dram row strobe monitor for the controller bench
`timescale 1ns/1ps
`default_nettype none
module dbd_proc_model (
  input wire logic mclk,
  input wire logic [1:0] ras_n,
  input wire logic [1:0] cas_n,
  input wire logic we_n,
  input wire logic [8:0] dram_addr,
  input wire logic ready_n,
  output logic cmd_rd_n,
  output logic cmd_wr_n,
  output logic port_enable_n,
  output logic bank_select_input,
  output logic [17:0] proc_addr
);
  int gap[2] = '{0, 0};
  int hi[2] = '{0, 0};
  initial begin
    cmd_rd_n = 1'b1;
    cmd_wr_n = 1'b1;
    port_enable_n = 1'b1;
    bank_select_input = 1'b0;
    proc_addr = 18'h0;
  end
  // ****************************************
  // row strobe high time per bank, as the array sees it
  // ****************************************
  always @(posedge mclk) begin
    for (int b = 0; b < 2; b++) begin
      if (ras_n[b] === 1'b1) begin
        hi[b] <= hi[b] + 1;
      end else if (hi[b] != 0) begin
        gap[b] <= hi[b];
        hi[b] <= 0;
      end
    end
  end
  // ****************************************
  // one processor access, held until ready
  // ****************************************
  task automatic access(input logic wr, input logic bank, input logic [17:0] a,
      output int lat, output logic [1:0] ras, output logic [1:0] cas, output logic we,
      output logic [8:0] row, output logic [8:0] col);
    bit got;
    got = 1'b0;
    lat = 0;
    ras = 2'h3;
    row = 9'h0;
    port_enable_n <= 1'b0;
    bank_select_input <= bank;
    proc_addr <= a;
    cmd_wr_n <= !wr;
    cmd_rd_n <= wr;
    // strobes and ready are looked at mid-cycle, where they are settled
    while (lat < 400) begin
      @(negedge mclk);
      lat++;
      if (!got && ras_n !== 2'h3 && ras_n !== 2'h0) begin
        got = 1'b1;
        ras = ras_n;
        row = dram_addr;
      end
      if (ready_n === 1'b0) break;
    end
    cas = cas_n;
    we = we_n;
    col = dram_addr;
    @(posedge mclk);
    cmd_rd_n <= 1'b1;
    cmd_wr_n <= 1'b1;
    port_enable_n <= 1'b1;
    proc_addr <= ~a;
    for (int i = 0; i < 20; i++) begin
      @(negedge mclk);
      if (ready_n === 1'b1) break;
    end
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// [test/tb_dual_bank_dram_controller.sv]
// self-checking bench for the dual bank dram controller
`timescale 1ns/1ps
`default_nettype none
module tb_dual_bank_dram_controller;
  localparam int EXP_IVL = 2000000 * 95 / (128 * 10 * 100);
  logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, cmd_rd_n, cmd_wr_n;
  logic port_enable_n, port_control, bank_select_input, refresh_request;
  logic program_data_input, we_n, ready_n, prog_shift_clk;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [17:0] proc_addr;
  logic [1:0] ras_n, cas_n, ras_p;
  logic [8:0] dram_addr;
  logic [7:0] row0;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n_wake = 0;
  int ref_t[$];
  int l0, l, k;
  dbd_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_rd_n(cmd_rd_n),
    .cmd_wr_n(cmd_wr_n), .port_enable_n(port_enable_n), .port_control(port_control),
    .bank_select_input(bank_select_input), .refresh_request(refresh_request),
    .program_data_input(program_data_input), .proc_addr(proc_addr), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .dram_addr(dram_addr), .ready_n(ready_n),
    .prog_shift_clk(prog_shift_clk));
  dbd_proc_model cpu (.mclk(mclk), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .dram_addr(dram_addr), .ready_n(ready_n), .cmd_rd_n(cmd_rd_n), .cmd_wr_n(cmd_wr_n),
    .port_enable_n(port_enable_n), .bank_select_input(bank_select_input),
    .proc_addr(proc_addr));
  always #5 mclk = ~mclk;
  // ****************************************
  // wake-up and refresh strobe monitor
  // ****************************************
  always @(posedge mclk) begin
    cyc <= sys_rst ? 0 : cyc + 1;
    ras_p <= ras_n;
    if (!sys_rst && ras_p === 2'h3 && ras_n === 2'h0) begin
      if (cyc < 310) n_wake <= n_wake + 1;
      else ref_t.push_back(cyc);
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] v);
    int i;
    bit ok;
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= w;
    avs_read <= !w;
    // look at waitrequest while it is settled, then let the accepting edge pass
    for (i = 0; i < 20; i++) begin
      @(negedge mclk);
      ok = (avs_waitrequest === 1'b0);
      d = avs_readdata;
      @(posedge mclk);
      if (ok) break;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
    if (i == 20) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic wait_cyc(input int n);
    while (cyc < n) @(posedge mclk);
  endtask
  task automatic run(input logic wr, input logic b, input logic [17:0] a, output int lat);
    logic [1:0] ras, cas;
    logic we;
    logic [8:0] row, col;
    cpu.access(wr, b, a, lat, ras, cas, we, row, col);
    if (lat >= 400) begin
      n_errors++;
      test_done();
    end
    chk("row strobes", 32'(b ? 2'h1 : 2'h2), 32'(ras));
    chk("column strobes", 32'(b ? 2'h1 : 2'h2), 32'(cas));
    chk("write enable", 32'(!wr), 32'(we));
    chk("row address", 32'(a[8:0]), 32'(row));
    chk("column address", 32'(a[17:9]), 32'(col));
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    port_control = 1'b1;
    refresh_request = 1'b0;
    program_data_input = 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("reset outputs", 32'h0000fff8, 32'({ras_n, cas_n, we_n, ready_n, prog_shift_clk,
      dram_addr}));
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    port_control <= 1'b0;
    $display("test reset done");
    wait_cyc(30);
    av(1'b0, 4'h4, 32'h0);
    chk("state programming", 32'h0, 32'(d[2:0]));
    chk("config word", 32'h02, 32'(d[10:3]));
    chk("straps", 32'h1, 32'(d[13:11]));
    wait_cyc(60);
    av(1'b0, 4'h4, 32'h0);
    chk("state early wake", 32'h1, 32'(d[2:0]));
    wait_cyc(285);
    av(1'b0, 4'h4, 32'h0);
    chk("state late wake", 32'h1, 32'(d[2:0]));
    wait_cyc(310);
    av(1'b0, 4'h4, 32'h0);
    chk("state idle", 32'h2, 32'(d[2:0]));
    chk("wake cycles", 32'h8, 32'(n_wake));
    $display("test startup done");
    run(1'b0, 1'b0, 18'h2a5b3, l0);
    run(1'b0, 1'b1, 18'h1c34e, l);
    chk("alternate bank latency", 32'(l0), 32'(l));
    run(1'b0, 1'b1, 18'h3fe01, l);
    chk("read after read latency", 32'(l0), 32'(l));
    run(1'b1, 1'b1, 18'h00ff0, l);
    chk("precharge after read", 32'h1, 32'(cpu.gap[1] >= dbd_pkg::RP_CYC));
    run(1'b1, 1'b1, 18'h3f00f, l);
    chk("precharge after write", 32'h1, 32'(cpu.gap[1] >= dbd_pkg::RP_CYC));
    $display("test access done");
    av(1'b0, 4'h4, 32'h0);
    row0 = d[21:14];
    av(1'b1, 4'h0, 32'h1);
    run(1'b0, 1'b0, 18'h12345, l);
    chk("refresh delays access", 32'h1, 32'(l > l0));
    av(1'b0, 4'h4, 32'h0);
    chk("refresh row step", 32'(row0 + 8'h1), 32'(d[21:14]));
    av(1'b1, 4'hc, 32'hffffffff);
    av(1'b0, 4'hc, 32'h0);
    chk("unmapped read", 32'h0, d);
    $display("test refresh request done");
    k = ref_t.size();
    for (int i = 0; i < 4000 && ref_t.size() < k + 2; i++) @(posedge mclk);
    if (ref_t.size() < k + 2) begin
      n_errors++;
      test_done();
    end
    l = ref_t[ref_t.size() - 1] - ref_t[ref_t.size() - 2];
    chk("refresh interval", 32'h1, 32'(l >= EXP_IVL - 2 && l <= EXP_IVL + 2));
    $display("test refresh interval done");
    test_done();
  end
endmodule
`default_nettype wire
